/* File: src/pwmsc_pkg.sv */
// pwmsc_pkg: constants and carriers for the pwm enable and sync control block
// assumes a single 200 mhz clock; all analog levels arrive as comparator bits
package pwmsc_pkg;

  localparam int unsigned CLK_MHZ        = 200;
  // least valid enable pulse width, in ns, and its cycle count (rounded up)
  localparam int unsigned EN_MIN_NS      = 3000;
  localparam int unsigned EN_MIN_CYC     = (EN_MIN_NS * CLK_MHZ + 999) / 1000;
  // soft-start ramp time from discharge to the pulse decision level, in ns
  localparam int unsigned SS_DEC_NS      = 10000;
  localparam int unsigned SS_DEC_CYC     = (SS_DEC_NS * CLK_MHZ) / 1000;
  // free-running oscillator period, in ns (2.5 us gives 400 khz)
  localparam int unsigned OSC_NS         = 2500;
  localparam int unsigned OSC_CYC        = (OSC_NS * CLK_MHZ) / 1000;
  // lowest sync frequency 170 khz: longest sync period in ns, rounded down
  localparam int unsigned SYNC_MAX_NS    = 5882;
  localparam int unsigned SYNC_MAX_CYC   = (SYNC_MAX_NS * CLK_MHZ) / 1000;
  localparam int unsigned CNT_W          = 16;
  localparam logic [CNT_W-1:0] CNT_ZERO  = 16'h0000;
  localparam logic [CNT_W-1:0] CNT_ONE   = 16'h0001;

  typedef enum logic [3:0] {
    PWMSC_STANDBY = 4'h1,
    PWMSC_IDLE    = 4'h2,
    PWMSC_SOFT    = 4'h4,
    PWMSC_RUN     = 4'h8
  } pwmsc_state_t;

  // start-up conditions, one comparator result each
  typedef struct packed {
    logic supply_above_rise;
    logic supply_above_fall;
    logic ref_valid;
    logic temp_ok;
    logic overvoltage_sense;
  } pwmsc_cond_t;

  // per-phase gate drive set
  typedef struct packed {
    logic primary_drive_a;
    logic primary_drive_b;
    logic rectifier_drive_a;
    logic rectifier_drive_b;
  } pwmsc_drive_t;

  // dead times as clock counts
  typedef struct packed {
    logic [7:0] rectifier_to_primary_delay;
    logic [7:0] primary_to_rectifier_delay;
  } pwmsc_dead_t;

endpackage : pwmsc_pkg

/* File: src/pwmsc_top.sv */
// pwmsc_top: start-up gating, enable decoding, oscillator, sync lock and
// two-phase primary / rectifier drive sequencing
// assumes all inputs synchronous to sys_clk_in and comparator levels digital
`timescale 1ns/1ps

module pwmsc_top
  import pwmsc_pkg::*;
(
  input  wire logic         sys_clk_in,
  input  wire logic         rst_n_in,
  input  wire pwmsc_cond_t  cond_in,
  input  wire logic         turn_on_req_in,
  input  wire logic         sync_clk_in,
  input  wire logic         sync_mode_in,
  input  wire logic         current_at_limit_in,
  input  wire logic         overcurrent_trip_in,
  input  wire logic         ramp_pulled_low_in,
  input  wire pwmsc_dead_t  dead_in,
  output logic              standby_out,
  output logic              ramp_charge_out,
  output logic              ramp_discharge_out,
  output logic              running_out,
  output pwmsc_drive_t      drive_out
);

  //////////////////////////////////////////////////////////////////////////
  // enable filter and soft-start model

  pwmsc_state_t     state_r, state_nxt;
  logic [CNT_W-1:0] en_cnt_r, en_cnt_nxt;
  logic             en_f_r, en_f_nxt;
  logic [CNT_W-1:0] ss_cnt_r, ss_cnt_nxt;
  logic             pulse_mode_r, pulse_mode_nxt;
  logic             en_rise, en_fall, start_ok, ss_at_dec;

  assign start_ok  = cond_in.supply_above_rise && cond_in.ref_valid
                     && cond_in.temp_ok && !cond_in.overvoltage_sense;
  assign ss_at_dec = (ss_cnt_r >= CNT_W'(SS_DEC_CYC));

  always_comb begin
    en_cnt_nxt = en_cnt_r;
    en_f_nxt   = en_f_r;
    // a level change only counts once it has held for the least width
    if (turn_on_req_in == en_f_r) begin
      en_cnt_nxt = CNT_ZERO;
    end else if (en_cnt_r >= CNT_W'(EN_MIN_CYC - 1)) begin
      en_f_nxt   = turn_on_req_in;
      en_cnt_nxt = CNT_ZERO;
    end else begin
      en_cnt_nxt = en_cnt_r + CNT_ONE;
    end
  end

  assign en_rise = en_f_nxt && !en_f_r;
  assign en_fall = !en_f_nxt && en_f_r;

  always_comb begin
    state_nxt      = state_r;
    ss_cnt_nxt     = ss_cnt_r;
    pulse_mode_nxt = pulse_mode_r;
    case (state_r)
      PWMSC_STANDBY: begin
        ss_cnt_nxt = CNT_ZERO;
        if (cond_in.supply_above_rise) begin
          state_nxt = PWMSC_IDLE;
        end
      end
      PWMSC_IDLE: begin
        ss_cnt_nxt     = CNT_ZERO;
        pulse_mode_nxt = 1'b0;
        if (en_rise && start_ok) begin
          state_nxt = PWMSC_SOFT;
        end
      end
      PWMSC_SOFT, PWMSC_RUN: begin
        if (overcurrent_trip_in || ramp_pulled_low_in) begin
          ss_cnt_nxt = CNT_ZERO;
          state_nxt  = PWMSC_SOFT;
        end else if (!ss_at_dec) begin
          ss_cnt_nxt = ss_cnt_r + CNT_ONE;
        end else begin
          state_nxt = PWMSC_RUN;
        end
        if (en_fall && !ss_at_dec) begin
          pulse_mode_nxt = 1'b1;
        end
        if (en_fall && ss_at_dec && !pulse_mode_r) begin
          state_nxt = PWMSC_IDLE;
        end
        if (en_rise && pulse_mode_r) begin
          state_nxt = PWMSC_IDLE;
        end
        if (!start_ok) begin
          state_nxt = PWMSC_IDLE;
        end
      end
      default: begin
        state_nxt = PWMSC_STANDBY;
      end
    endcase
    if (!cond_in.supply_above_fall) begin
      state_nxt = PWMSC_STANDBY;
    end
  end

  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state_r      <= PWMSC_STANDBY;
      en_cnt_r     <= CNT_ZERO;
      en_f_r       <= 1'b0;
      ss_cnt_r     <= CNT_ZERO;
      pulse_mode_r <= 1'b0;
    end else begin
      state_r      <= state_nxt;
      en_cnt_r     <= en_cnt_nxt;
      en_f_r       <= en_f_nxt;
      ss_cnt_r     <= ss_cnt_nxt;
      pulse_mode_r <= pulse_mode_nxt;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // oscillator with sync lock and low-frequency clamp

  logic [CNT_W-1:0] osc_cnt_r, osc_cnt_nxt;
  logic             sync_d_r, sync_d_nxt;
  logic             osc_tick, sync_fall, active;

  // decoded from the next state so drives drop on the same edge as the
  // registered status outputs, never one cycle behind them
  assign active    = (state_nxt == PWMSC_SOFT) || (state_nxt == PWMSC_RUN);
  assign sync_fall = sync_d_r && !sync_clk_in;

  always_comb begin
    sync_d_nxt  = sync_clk_in;
    osc_tick    = 1'b0;
    osc_cnt_nxt = osc_cnt_r + CNT_ONE;
    if (sync_mode_in) begin
      // the clamp tick fires before a late sync edge, which still ticks when it comes
      if (sync_fall) begin
        osc_tick = 1'b1;
      end else if (osc_cnt_r >= CNT_W'(SYNC_MAX_CYC - 1)) begin
        osc_tick = 1'b1;
      end
    end else if (osc_cnt_r >= CNT_W'(OSC_CYC - 1)) begin
      osc_tick = 1'b1;
    end
    if (osc_tick) begin
      osc_cnt_nxt = CNT_ZERO;
    end
  end

  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      osc_cnt_r <= CNT_ZERO;
      sync_d_r  <= 1'b0;
    end else begin
      osc_cnt_r <= osc_cnt_nxt;
      sync_d_r  <= sync_d_nxt;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // drive sequencing: phase toggles each tick, so each output runs at half

  logic             phase_r, phase_nxt;
  logic             prim_on_r, prim_on_nxt;
  logic [7:0]       dly_r, dly_nxt;
  logic             wait_on_r, wait_on_nxt;
  pwmsc_drive_t     drv_nxt, drv_r;

  always_comb begin
    phase_nxt   = phase_r;
    prim_on_nxt = prim_on_r;
    dly_nxt     = dly_r;
    wait_on_nxt = wait_on_r;
    drv_nxt     = drv_r;
    if (!active) begin
      drv_nxt     = '0;
      prim_on_nxt = 1'b0;
      wait_on_nxt = 1'b0;
    end else if (osc_tick) begin
      phase_nxt   = !phase_r;
      // rectifier of the new phase falls first, primary follows after delay
      drv_nxt.rectifier_drive_a = phase_r;
      drv_nxt.rectifier_drive_b = !phase_r;
      drv_nxt.primary_drive_a   = 1'b0;
      drv_nxt.primary_drive_b   = 1'b0;
      prim_on_nxt = 1'b0;
      wait_on_nxt = 1'b1;
      dly_nxt     = dead_in.rectifier_to_primary_delay;
    end else if (wait_on_r) begin
      if (dly_r == 8'h00) begin
        wait_on_nxt = 1'b0;
        prim_on_nxt = 1'b1;
        drv_nxt.primary_drive_a = phase_r;
        drv_nxt.primary_drive_b = !phase_r;
      end else begin
        dly_nxt = dly_r - 8'h01;
      end
    end else if (prim_on_r && current_at_limit_in) begin
      drv_nxt.primary_drive_a = 1'b0;
      drv_nxt.primary_drive_b = 1'b0;
      prim_on_nxt = 1'b0;
    end
  end

  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      phase_r   <= 1'b0;
      prim_on_r <= 1'b0;
      dly_r     <= 8'h00;
      wait_on_r <= 1'b0;
      drv_r     <= '0;
    end else begin
      phase_r   <= phase_nxt;
      prim_on_r <= prim_on_nxt;
      dly_r     <= dly_nxt;
      wait_on_r <= wait_on_nxt;
      drv_r     <= drv_nxt;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // registered status outputs

  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      standby_out        <= 1'b1;
      ramp_charge_out    <= 1'b0;
      ramp_discharge_out <= 1'b1;
      running_out        <= 1'b0;
    end else begin
      standby_out        <= (state_nxt == PWMSC_STANDBY);
      ramp_charge_out    <= (state_nxt == PWMSC_SOFT);
      ramp_discharge_out <= (state_nxt == PWMSC_STANDBY)
                            || (state_nxt == PWMSC_IDLE);
      running_out        <= (state_nxt == PWMSC_RUN);
    end
  end

  assign drive_out = drv_r;

endmodule : pwmsc_top

/* File: test/pwmsc_monitor.sv */
// pwmsc_monitor: concurrent checks on the ports of pwmsc_top
// assumes one clock domain with an asynchronous active-low reset
`timescale 1ns/1ps
module pwmsc_monitor
  import pwmsc_pkg::*;
(
  input  wire logic         sys_clk_in,
  input  wire logic         rst_n_in,
  input  wire pwmsc_cond_t  cond_in,
  input  wire logic         turn_on_req_in,
  input  wire logic         current_at_limit_in,
  input  wire logic         standby_out,
  input  wire logic         ramp_charge_out,
  input  wire logic         ramp_discharge_out,
  input  wire logic         running_out,
  input  wire pwmsc_drive_t drive_out
);
////////////////////////////////////////////////////////////////////////////
  // length of the current high run of the request
  logic [CNT_W-1:0] hi_r;
  logic [CNT_W-1:0] hi_nxt;
  wire start_ok = cond_in.supply_above_rise & cond_in.ref_valid
                & cond_in.temp_ok & ~cond_in.overvoltage_sense;
  always_comb begin
    hi_nxt = turn_on_req_in ? hi_r + CNT_ONE : CNT_ZERO;
  end
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) hi_r <= CNT_ZERO;
    else hi_r <= hi_nxt;
  end
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!rst_n_in);
  a_start_gate: assert property (
    $rose(ramp_charge_out) |-> $past(start_ok))
    else $error("ramp charge with a start condition failing");
  a_standby_quiet: assert property (
    standby_out |-> drive_out == 4'h0 && !ramp_charge_out)
    else $error("activity in standby");
  a_supply_drop: assert property (
    !cond_in.supply_above_fall |=> standby_out)
    else $error("no standby after supply drop");
  a_idle_quiet: assert property (
    ramp_discharge_out |-> drive_out == 4'h0 && !running_out)
    else $error("drive active while ramp discharged");
  a_primary_excl: assert property (
    !(drive_out.primary_drive_a && drive_out.primary_drive_b))
    else $error("both primaries on");
  a_rect_first: assert property (
    $rose(drive_out.primary_drive_a) |-> !drive_out.rectifier_drive_a
      && $past(!drive_out.rectifier_drive_a))
    else $error("rectifier a still on at primary a rise");
  a_limit_off: assert property (
    drive_out.primary_drive_a && current_at_limit_in
      |=> !drive_out.primary_drive_a)
    else $error("primary a kept on at current limit");
  a_short_pulse: assert property (
    $fell(turn_on_req_in) && ramp_discharge_out && hi_r < EN_MIN_CYC - 2
      |-> !ramp_charge_out [*8])
    else $error("short request pulse started the ramp");
  c_run: cover property ($rose(running_out));
  c_prim_b: cover property ($rose(drive_out.primary_drive_b));
  c_standby: cover property ($rose(standby_out));
endmodule : pwmsc_monitor
////////////////////////////////////////////////////////////////////////////
bind pwmsc_top pwmsc_monitor pwmsc_monitor_i (.sys_clk_in, .rst_n_in,
  .cond_in, .turn_on_req_in, .current_at_limit_in, .standby_out,
  .ramp_charge_out, .ramp_discharge_out, .running_out, .drive_out);

/* File: test/pwmsc_partner.sv */
// pwmsc_partner: enable source and sync clock source
// assumes the bench calls its tasks from one process
`timescale 1ns/1ps
module pwmsc_partner (
  input  wire logic clk_in,
  output logic      req_out,
  output logic      sync_out
);
  int unsigned half_r = 0;
  int unsigned cnt_r  = 0;
  initial begin
    req_out  = 1'b0;
    sync_out = 1'b1;
  end
  // equal halves for even interleaving; half_r of 0 parks the clock high
  always @(posedge clk_in) begin
    cnt_r <= (half_r == 0 || cnt_r + 1 >= half_r) ? 0 : cnt_r + 1;
    if (half_r == 0) sync_out <= 1'b1;
    else if (cnt_r + 1 >= half_r) sync_out <= ~sync_out;
  end
  // held for n cycles; the bench may ask for less than the minimum
  task hold(input int unsigned n);
    @(posedge clk_in);
    req_out <= 1'b1;
    repeat (n) @(posedge clk_in);
    req_out <= 1'b0;
  endtask : hold
  task set_req(input logic v);
    @(posedge clk_in);
    req_out <= v;
  endtask : set_req
endmodule : pwmsc_partner

/* File: test/pwmsc_top_test.sv */
// pwmsc_top_test: self-checking bench for pwmsc_top
// assumes pwmsc_partner drives the request and the sync clock
`timescale 1ns/1ps
module pwmsc_top_test;
  import pwmsc_pkg::*;
  logic         sys_clk_in = 1'b0;
  logic         rst_n_in = 1'b0;
  pwmsc_cond_t  cond_in = 5'h1e;
  logic         sync_mode_in = 1'b0;
  logic         current_at_limit_in = 1'b0;
  logic         overcurrent_trip_in = 1'b0;
  logic         ramp_pulled_low_in = 1'b0;
  pwmsc_dead_t  dead_in = 16'h0400;
  logic         turn_on_req_in, sync_clk_in, standby_out, running_out;
  logic         ramp_charge_out, ramp_discharge_out;
  pwmsc_drive_t drive_out;
  int           failures = 0;
  int           tests_run = 0;
  int           n;
  wire [7:0]    st = {standby_out, ramp_charge_out, ramp_discharge_out,
                      running_out, drive_out};
  always #2.5 sys_clk_in = ~sys_clk_in;
  pwmsc_top pwmsc_top_i (.sys_clk_in, .rst_n_in, .cond_in, .turn_on_req_in,
    .sync_clk_in, .sync_mode_in, .current_at_limit_in, .overcurrent_trip_in,
    .ramp_pulled_low_in, .dead_in, .standby_out,
    .ramp_charge_out, .ramp_discharge_out, .running_out, .drive_out);
  pwmsc_partner pwmsc_partner_i (.clk_in(sys_clk_in),
    .req_out(turn_on_req_in), .sync_out(sync_clk_in));
////////////////////////////////////////////////////////////////////////////
  task chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // bounded wait for status bit b to reach v; n counts the edges
  task wt(input int b, input logic v);
    n = 0;
    do begin
      @(posedge sys_clk_in);
      #1 n++;
    end while (st[b] !== v && n < 4000);
    if (st[b] !== v) begin
      failures++;
      $display("ERROR t=%0t wait st=%h exp=%h", $time, st, v);
    end
  endtask : wt
  task cyc(input int k);
    repeat (k) @(posedge sys_clk_in);
    #1;
  endtask : cyc
  task t_gate;
    pwmsc_partner_i.hold(300);
    cyc(800); chk(16'(st[6]), 16'h0);
    // one failing start condition at a time; the wait lets the filter fall
    for (int i = 0; i < 5; i++) begin
      @(posedge sys_clk_in) cond_in <= 5'h1e ^ (5'h01 << i);
      pwmsc_partner_i.hold(700);
      cyc(100); chk(16'(st[6]), 16'h0);
      @(posedge sys_clk_in) cond_in <= 5'h1e;
      cyc(700);
    end
    $display("gate test done");
  endtask : t_gate
  task t_level;
    pwmsc_partner_i.set_req(1'b1);
    wt(6, 1'b1); chk(16'(n >= 600 && n <= 603), 16'h1);
    wt(4, 1'b1); wt(1, 1'b1); wt(1, 1'b0);
    wt(3, 1'b1); chk(16'(n), 16'h5);
    wt(2, 1'b1); chk(16'(n), 16'(OSC_CYC));
    wt(3, 1'b1);
    @(posedge sys_clk_in) current_at_limit_in <= 1'b1;
    cyc(1); chk(16'(st[3]), 16'h0);
    @(posedge sys_clk_in) current_at_limit_in <= 1'b0;
    @(posedge sys_clk_in) ramp_pulled_low_in <= 1'b1;
    @(posedge sys_clk_in) ramp_pulled_low_in <= 1'b0;
    cyc(1); chk(16'(st[6:4]), 16'h4);
    wt(4, 1'b1);
    pwmsc_partner_i.set_req(1'b0);
    cyc(700); chk(16'(st[5:0]), 16'h20);
    $display("level test done");
  endtask : t_level
  task t_pulse(input logic trip);
    if (trip) begin
      pwmsc_partner_i.set_req(1'b1);
      wt(4, 1'b1);
      @(posedge sys_clk_in) overcurrent_trip_in <= 1'b1;
      @(posedge sys_clk_in) overcurrent_trip_in <= 1'b0;
      pwmsc_partner_i.set_req(1'b0);
    end else pwmsc_partner_i.hold(700);
    cyc(3000); chk(16'(st[4]), 16'h1);
    pwmsc_partner_i.hold(700);
    cyc(10); chk(16'(st[4]), 16'h0);
    cyc(700);
    $display("pulse test done");
  endtask : t_pulse
  task t_sync;
    @(posedge sys_clk_in) sync_mode_in <= 1'b1;
    dead_in <= 16'h0000;
    pwmsc_partner_i.half_r <= 300;
    pwmsc_partner_i.set_req(1'b1);
    wt(4, 1'b1); wt(1, 1'b1); wt(1, 1'b0);
    wt(3, 1'b1); chk(16'(n), 16'h1);
    wt(2, 1'b1); chk(16'(n), 16'h258);
    pwmsc_partner_i.half_r = 800;
    wt(3, 1'b1); wt(3, 1'b0); wt(3, 1'b1);
    wt(2, 1'b1); chk(16'(n <= SYNC_MAX_CYC), 16'h1);
    @(posedge sys_clk_in) cond_in.supply_above_fall <= 1'b0;
    cyc(2); chk(16'(st[7]), 16'h1);
    chk(16'(st[3:0]), 16'h0);
    $display("sync test done");
  endtask : t_sync
  task end_sim;
    $display("checks %0d failures %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : end_sim
  initial begin
    repeat (4) @(posedge sys_clk_in);
    rst_n_in <= 1'b1;
    t_gate();
    t_level();
    t_pulse(1'b0);
    t_pulse(1'b1);
    t_sync();
    end_sim();
  end
  // all scenarios need some 35000 cycles
  initial begin
    repeat (80000) @(posedge sys_clk_in);
    failures++;
    end_sim();
  end
endmodule : pwmsc_top_test
